//--- src/alu_ops_cfg.svh
/*
  Register map, field positions, reset values and opcode patterns for the
  small three-instruction execution block.
  Assumes it is included by bare name, before the package, and that the
  APB master presents byte addresses of 12 bits.
*/
`ifndef ALU_OPS_CFG_SVH
`define ALU_OPS_CFG_SVH

// ---------------------------------------------------------------
// register byte offsets
// ---------------------------------------------------------------
`define OFF_INSTR 12'h000
`define OFF_WORK 12'h004
`define OFF_STATUS 12'h008
`define OFF_COUNT 12'h00c
`define FILE_BASE_HI 3'h1

// ---------------------------------------------------------------
// status fields
// ---------------------------------------------------------------
`define ST_CARRY 0
`define ST_DIGIT 1
`define ST_ZERO 2
`define ST_BUSY 3
`define ST_UNSUP 4

// ---------------------------------------------------------------
// reset values
// ---------------------------------------------------------------
`define RST_WORK 8'h00
`define RST_INSTR 14'h0000
`define RST_COUNT 16'h0000

// ---------------------------------------------------------------
// opcode patterns
// ---------------------------------------------------------------
`define PAT_ADD_LIT 5'h1f
`define PAT_AND_LIT 6'h39
`define PAT_ADD_REG 6'h07

`endif

//--- src/alu_ops_pkg.sv
/*
  Types shared by the execution block and its helpers.
  Assumes nothing beyond a SystemVerilog compiler.
*/
`default_nettype none

package alu_ops_pkg;

  // gray codes along idle, q1, q2, q3, q4
  typedef enum logic [2:0] {
    ST_IDLE = 3'h0,
    ST_Q1 = 3'h1,
    ST_Q2 = 3'h3,
    ST_Q3 = 3'h2,
    ST_Q4 = 3'h6
  } phase_t;

  typedef enum logic [1:0] {
    OP_NONE = 2'h0,
    OP_ADD = 2'h1,
    OP_AND = 2'h2
  } alu_op_t;

endpackage : alu_ops_pkg

`default_nettype wire

//--- src/alu_unit.sv
/*
  Combinational datapath: 8-bit add with carry and digit carry, and AND.
  Assumes operands are held stable by the caller for the process phase.
*/
`default_nettype none

module alu_unit
  import alu_ops_pkg::*;
(
  input wire alu_op_t op,
  input wire logic [7:0] a,
  input wire logic [7:0] b,
  output logic [7:0] y,
  output logic carry,
  output logic digit
);

  wire logic [8:0] sum;
  wire logic [4:0] low_sum;

  assign sum = {1'b0, a} + {1'b0, b};
  assign low_sum = {1'b0, a[3:0]} + {1'b0, b[3:0]};

  always_comb begin
    y = 8'h00;
    carry = 1'b0;
    digit = 1'b0;
    unique case (op)
      OP_ADD: begin
        y = sum[7:0];
        carry = sum[8];
        digit = low_sum[4];
      end
      OP_AND: begin
        y = a & b;
      end
      OP_NONE: begin
        y = 8'h00;
      end
    endcase
  end

endmodule : alu_unit

`default_nettype wire

//--- src/file_ram.sv
/*
  128 x 8 file register store, synchronous write, asynchronous read.
  Assumes at most one writer per cycle; contents are not reset.
*/
`default_nettype none

module file_ram (
  input wire logic clk,
  input wire logic we,
  input wire logic [6:0] waddr,
  input wire logic [7:0] wdata,
  input wire logic [6:0] raddr,
  output logic [7:0] rdata
);

  logic [7:0] mem [0:127];

  always_ff @(posedge clk) begin
    if (we) begin
      mem[waddr] <= wdata;
    end
  end

  assign rdata = mem[raddr];

endmodule : file_ram

`default_nettype wire

//--- src/add_and_alu_ops.sv
/*
  Execution block for add-literal, add-register and and-literal, with an
  APB slave for the instruction, work register, status, retired count and
  the 128 file registers.
  Assumes an APB master that holds each request stable until answered;
  the block runs on pclk with asynchronous active-low presetn.
*/
// Added by the designer: the placing of the registers and the APB register port.
`default_nettype none

`include "alu_ops_cfg.svh"

module add_and_alu_ops
  import alu_ops_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr
);

  // ---------------------------------------------------------------
  // functions
  // ---------------------------------------------------------------
  function automatic alu_op_t decode_op(input logic [13:0] w);
    alu_op_t r;
    r = OP_NONE;
    if (w[13:9] == `PAT_ADD_LIT) begin
      r = OP_ADD;
    end else if (w[13:8] == `PAT_AND_LIT) begin
      r = OP_AND;
    end else if (w[13:8] == `PAT_ADD_REG) begin
      r = OP_ADD;
    end
    return r;
  endfunction : decode_op

  function automatic logic uses_file(input logic [13:0] w);
    return w[13:8] == `PAT_ADD_REG;
  endfunction : uses_file

  function automatic logic is_zero(input logic [7:0] v);
    return v == 8'h00;
  endfunction : is_zero

  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  phase_t state_q;
  phase_t state_d;
  logic [13:0] instr_q;
  alu_op_t op_q;
  logic file_src_q;
  logic dest_file_q;
  logic [7:0] opnd_q;
  logic [7:0] res_q;
  logic cout_q;
  logic dcout_q;
  logic [7:0] work_q;
  logic carry_q;
  logic digit_carry_flag_q;
  logic zero_q;
  logic unsup_q;
  logic [15:0] count_q;
  logic [31:0] prdata_q;
  logic pready_q;
  logic pslverr_q;

  // ---------------------------------------------------------------
  // bus decode
  // ---------------------------------------------------------------
  wire logic busy;
  wire logic answer;
  wire logic done;
  wire logic wr_done;
  wire logic sel_instr;
  wire logic sel_work;
  wire logic sel_status;
  wire logic sel_count;
  wire logic sel_file;
  wire logic mapped;
  wire logic [6:0] bus_faddr;

  assign busy = state_q != ST_IDLE;
  // any access waits for idle, so bus and core never touch one
  // register in the same cycle; the wait is at most four cycles
  assign answer = psel & penable & ~pready_q & ~busy;
  assign done = psel & penable & pready_q;
  assign wr_done = done & pwrite;

  assign sel_instr = paddr == `OFF_INSTR;
  assign sel_work = paddr == `OFF_WORK;
  assign sel_status = paddr == `OFF_STATUS;
  assign sel_count = paddr == `OFF_COUNT;
  assign sel_file = (paddr[11:9] == `FILE_BASE_HI) &
                    (paddr[1:0] == 2'h0);
  assign mapped = sel_instr | sel_work | sel_status | sel_count |
                  sel_file;
  assign bus_faddr = paddr[8:2];

  // ---------------------------------------------------------------
  // instruction fields
  // ---------------------------------------------------------------
  wire logic launch;
  wire alu_op_t dec_op;
  wire logic dec_file;
  wire logic dec_dest;
  wire logic [6:0] instr_faddr;
  wire logic [7:0] literal;

  assign launch = wr_done & sel_instr;
  assign dec_op = decode_op(instr_q);
  assign dec_file = uses_file(instr_q);
  assign dec_dest = dec_file & instr_q[7];
  assign instr_faddr = instr_q[6:0];
  assign literal = instr_q[7:0];

  // ---------------------------------------------------------------
  // phase sequencer
  // ---------------------------------------------------------------
  always_comb begin
    state_d = state_q;
    unique case (state_q)
      ST_IDLE: begin
        if (launch) begin
          state_d = ST_Q1;
        end
      end
      ST_Q1: begin
        state_d = ST_Q2;
      end
      ST_Q2: begin
        state_d = ST_Q3;
      end
      ST_Q3: begin
        state_d = ST_Q4;
      end
      ST_Q4: begin
        state_d = ST_IDLE;
      end
      default: begin
        state_d = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_q <= ST_IDLE;
    end else begin
      state_q <= state_d;
    end
  end

  wire logic in_q1;
  wire logic in_q2;
  wire logic in_q3;
  wire logic in_q4;

  assign in_q1 = state_q == ST_Q1;
  assign in_q2 = state_q == ST_Q2;
  assign in_q3 = state_q == ST_Q3;
  assign in_q4 = state_q == ST_Q4;

  // ---------------------------------------------------------------
  // file registers and datapath
  // ---------------------------------------------------------------
  wire logic [7:0] file_rdata;
  wire logic [6:0] file_raddr;
  wire logic file_we;
  wire logic [6:0] file_waddr;
  wire logic [7:0] file_wdata;
  wire logic core_to_file;
  wire logic core_to_work;
  wire logic [7:0] alu_y;
  wire logic alu_c;
  wire logic alu_digit;

  assign file_raddr = busy ? instr_faddr : bus_faddr;
  assign core_to_file = in_q4 & (op_q != OP_NONE) & dest_file_q;
  assign core_to_work = in_q4 & (op_q != OP_NONE) & ~dest_file_q;
  assign file_we = core_to_file | (wr_done & sel_file);
  assign file_waddr = core_to_file ? instr_faddr : bus_faddr;
  assign file_wdata = core_to_file ? res_q : pwdata[7:0];

  file_ram u_file (
    .clk(pclk),
    .we(file_we),
    .waddr(file_waddr),
    .wdata(file_wdata),
    .raddr(file_raddr),
    .rdata(file_rdata)
  );

  alu_unit u_alu (
    .op(op_q),
    .a(work_q),
    .b(opnd_q),
    .y(alu_y),
    .carry(alu_c),
    .digit(alu_digit)
  );

  // ---------------------------------------------------------------
  // instruction register and decode latch
  // ---------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      instr_q <= `RST_INSTR;
    end else if (launch) begin
      instr_q <= pwdata[13:0];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      op_q <= OP_NONE;
      file_src_q <= 1'b0;
      dest_file_q <= 1'b0;
    end else if (in_q1) begin
      op_q <= dec_op;
      file_src_q <= dec_file;
      dest_file_q <= dec_dest;
    end
  end

  // operand read: literal or addressed file register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      opnd_q <= 8'h00;
    end else if (in_q2) begin
      opnd_q <= file_src_q ? file_rdata : literal;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      res_q <= 8'h00;
      cout_q <= 1'b0;
      dcout_q <= 1'b0;
    end else if (in_q3) begin
      res_q <= alu_y;
      cout_q <= alu_c;
      dcout_q <= alu_digit;
    end
  end

  // ---------------------------------------------------------------
  // work register and flags
  // ---------------------------------------------------------------
  wire logic flag_wr;
  wire logic upd_arith;
  wire logic upd_zero;

  assign flag_wr = wr_done & sel_status;
  assign upd_arith = in_q4 & (op_q == OP_ADD);
  // and-literal touches only zero, carry pair is left alone
  assign upd_zero = in_q4 & (op_q != OP_NONE);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      work_q <= `RST_WORK;
    end else if (core_to_work) begin
      work_q <= res_q;
    end else if (wr_done & sel_work) begin
      work_q <= pwdata[7:0];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      carry_q <= 1'b0;
      digit_carry_flag_q <= 1'b0;
    end else if (upd_arith) begin
      carry_q <= cout_q;
      digit_carry_flag_q <= dcout_q;
    end else if (flag_wr) begin
      carry_q <= pwdata[`ST_CARRY];
      digit_carry_flag_q <= pwdata[`ST_DIGIT];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      zero_q <= 1'b0;
    end else if (upd_zero) begin
      zero_q <= is_zero(res_q);
    end else if (flag_wr) begin
      zero_q <= pwdata[`ST_ZERO];
    end
  end

  // sticky mark for a word that is none of the three; it runs as a
  // four-phase no-op. set beats a write-one clear.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      unsup_q <= 1'b0;
    end else if (in_q1 & (dec_op == OP_NONE)) begin
      unsup_q <= 1'b1;
    end else if (flag_wr & pwdata[`ST_UNSUP]) begin
      unsup_q <= 1'b0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      count_q <= `RST_COUNT;
    end else if (in_q4) begin
      count_q <= count_q + 16'h0001;
    end
  end

  // ---------------------------------------------------------------
  // read mux and answer
  // ---------------------------------------------------------------
  wire logic [31:0] status_word;
  wire logic [31:0] read_mux;

  assign status_word = {27'h0000000, unsup_q, busy, zero_q,
                        digit_carry_flag_q, carry_q};
  assign read_mux = sel_instr ? {18'h00000, instr_q} :
                    sel_work ? {24'h000000, work_q} :
                    sel_status ? status_word :
                    sel_count ? {16'h0000, count_q} :
                    sel_file ? {24'h000000, file_rdata} :
                    32'h00000000;

  // pready rises in the second access cycle when idle; one wait state buys a
  // registered answer
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q <= 32'h00000000;
    end else begin
      pready_q <= answer;
      pslverr_q <= answer & ~mapped;
      if (answer) begin
        prdata_q <= pwrite ? 32'h00000000 : read_mux;
      end
    end
  end

  assign prdata = prdata_q;
  assign pready = pready_q;
  assign pslverr = pslverr_q;

endmodule : add_and_alu_ops

`default_nettype wire

//--- dv/prog_mem.sv
/*
  Program memory model: a few fixed 14-bit instruction words, one per pc.
  Assumes the bench holds pc steady for a few cycles before it uses word.
*/
`default_nettype none

module prog_mem (
  input wire logic [3:0] pc,
  output logic [13:0] word
);
  timeunit 1ns;
  timeprecision 1ps;

  // ---------------------------------------------------------------
  // instruction words
  // ---------------------------------------------------------------
  always_comb begin
    case (pc)
      4'h0: word = 14'h3e15;
      4'h1: word = 14'h3f01;
      4'h2: word = 14'h3e08;
      4'h3: word = 14'h077f;
      4'h4: word = 14'h0780;
      4'h5: word = 14'h395f;
      4'h6: word = 14'h3900;
      // outside the three supported patterns
      default: word = 14'h3400;
    endcase
  end
endmodule : prog_mem

`default_nettype wire

//--- dv/add_and_alu_ops_monitor.sv
/*
  Port checker for add_and_alu_ops, bound to the top module.
  Assumes the APB master holds each request until pready.
*/
`default_nettype none

`include "alu_ops_cfg.svh"

module add_and_alu_ops_monitor (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr
);
  timeunit 1ns;
  timeprecision 1ps;

  // ---------------------------------------------------------------
  // decode of the answered transfer
  // ---------------------------------------------------------------
  wire logic done = psel && penable && pready;
  wire logic in_map = paddr[11:4] == 8'h00 || paddr[11:9] == `FILE_BASE_HI;
  wire logic mapped = in_map && paddr[1:0] == 2'h0;
  wire logic rd_done = done && !pwrite;
  wire logic instr_wr = done && pwrite && paddr == `OFF_INSTR;

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  // ---------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------
  a_err_with_ready: assert property (pslverr |-> pready && psel && penable)
    else $error("pslverr without an answered access");
  a_ready_pulse: assert property (pready |=> !pready)
    else $error("pready held longer than one cycle");
  a_ready_access: assert property (pready |-> psel && penable)
    else $error("pready outside an access phase");
  a_first_access: assert property ($rose(penable) && psel |-> !pready)
    else $error("pready in the first access cycle");
  a_ready_bound: assert property (psel && penable |-> ##[0:6] pready)
    else $error("access not answered in time");
  a_exec_stall: assert property (instr_wr |=> !pready [*4])
    else $error("access answered during execution");
  a_unmapped_err: assert property (done && !in_map |-> pslverr && !prdata)
    else $error("unmapped access not refused");
  a_mapped_ok: assert property (done && mapped |-> !pslverr)
    else $error("mapped access refused");
  a_work_width: assert property (
    rd_done && paddr == `OFF_WORK |-> prdata[31:8] == 24'h0)
    else $error("work read has upper bits set");
  a_file_width: assert property (
    rd_done && paddr[11:9] == `FILE_BASE_HI |-> prdata[31:8] == 24'h0)
    else $error("file read has upper bits set");
  a_idle_busy: assert property (
    rd_done && paddr == `OFF_STATUS |-> !prdata[`ST_BUSY])
    else $error("busy seen on an answered status read");

  c_exec: cover property (instr_wr);
  c_refused: cover property (done && pslverr);
  c_status_rd: cover property (rd_done && paddr == `OFF_STATUS);
endmodule : add_and_alu_ops_monitor

bind add_and_alu_ops add_and_alu_ops_monitor mon (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
  .pready(pready), .pslverr(pslverr)
);

`default_nettype wire

//--- dv/tb_top.sv
/*
  Bench for add_and_alu_ops: APB tasks run words from prog_mem and
  compare work, status and file registers. Assumes the design files and
  the monitor are compiled before it.
*/
`default_nettype none

`include "alu_ops_cfg.svh"

module tb_top;
  timeunit 1ns;
  timeprecision 1ps;

  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, er;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [3:0] pc;
  logic [13:0] word;
  int n_mismatch, n_compared;

  add_and_alu_ops uut (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr));
  prog_mem pm (.pc(pc), .word(word));

  initial begin
    pclk = 1'b0;
    forever #2.5 pclk = ~pclk;
  end

  task automatic end_sim();
    if (n_mismatch == 0 && n_compared > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : end_sim

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
      n_mismatch++;
    end
  endtask : chk

  // ---------------------------------------------------------------
  // one APB transfer; read data and error land in rd and er
  // ---------------------------------------------------------------
  task automatic apb(input logic wr, input logic [11:0] a,
                     input logic [31:0] wd);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    // no local limit: a missing answer is left to the watchdog
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  // ---------------------------------------------------------------
  // preset work, flags and file, execute word at p, compare all three
  // ---------------------------------------------------------------
  task automatic run(input logic [3:0] p, input logic [7:0] w0,
                     input logic [7:0] f0, input logic [2:0] st0);
    logic [13:0] w;
    logic [11:0] fa;
    logic [8:0] s;
    logic [7:0] b, ew, ef;
    logic [4:0] est;
    pc <= p;
    apb(1'b1, `OFF_WORK, {24'h0, w0});
    apb(1'b1, `OFF_STATUS, {29'h0, st0});
    w = word;
    fa = {`FILE_BASE_HI, w[6:0], 2'h0};
    apb(1'b1, fa, {24'h0, f0});
    ew = w0;
    ef = f0;
    est = {2'h0, st0};
    b = (w[13:9] == `PAT_ADD_LIT) ? w[7:0] : f0;
    if (w[13:9] == `PAT_ADD_LIT || w[13:8] == `PAT_ADD_REG) begin
      s = w0 + b;
      est[`ST_CARRY] = s[8];
      est[`ST_DIGIT] = ({1'b0, w0[3:0]} + b[3:0]) > 5'hf;
      est[`ST_ZERO] = s[7:0] == 8'h00;
      if (w[13:9] != `PAT_ADD_LIT && w[7]) ef = s[7:0];
      else ew = s[7:0];
    end else if (w[13:8] == `PAT_AND_LIT) begin
      ew = w0 & w[7:0];
      est[`ST_ZERO] = ew == 8'h00;
    end else begin
      est[`ST_UNSUP] = 1'b1;
    end
    apb(1'b1, `OFF_INSTR, {18'h0, w});
    apb(1'b0, `OFF_WORK, 32'h0);
    chk(rd, {24'h0, ew});
    apb(1'b0, `OFF_STATUS, 32'h0);
    chk(rd, {27'h0, est});
    apb(1'b0, fa, 32'h0);
    chk(rd, {24'h0, ef});
  endtask : run

  initial begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
    pc = 4'h0;
    presetn = 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, `OFF_INSTR, 32'h0);
    chk(rd, 32'h0);
    apb(1'b0, `OFF_STATUS, 32'h0);
    chk(rd, 32'h0);
    apb(1'b0, `OFF_COUNT, 32'h0);
    chk(rd, 32'h0);
    run(4'h0, 8'h10, 8'h33, 3'h0);
    run(4'h1, 8'hff, 8'h44, 3'h0);
    run(4'h2, 8'h08, 8'h55, 3'h5);
    run(4'h3, 8'h17, 8'hc2, 3'h0);
    run(4'h4, 8'h80, 8'h80, 3'h0);
    run(4'h5, 8'ha3, 8'h66, 3'h3);
    run(4'h6, 8'ha3, 8'h77, 3'h3);
    run(4'h7, 8'h55, 8'h11, 3'h0);
    // sticky bit clears on a written one
    apb(1'b1, `OFF_STATUS, 32'h10);
    apb(1'b0, `OFF_STATUS, 32'h0);
    chk(rd, 32'h0);
    apb(1'b1, `OFF_COUNT, 32'hffff);
    apb(1'b0, `OFF_COUNT, 32'h0);
    chk(rd, 32'h8);
    apb(1'b0, 12'h010, 32'h0);
    chk({31'h0, er}, 32'h1);
    chk(rd, 32'h0);
    end_sim();
  end

  initial begin
    #100000;
    n_mismatch++;
    end_sim();
  end
endmodule : tb_top

`default_nettype wire
